/* core/frx_pkg.sv */
// Shared constants, types and 5B lookup for the 100 Mb/s receive PCS
// Assumes a 10 MHz clock carrying one received line symbol per cycle
`default_nettype none

package frx_pkg;

	// ********************************
	// Timing
	// ********************************
	localparam int CLK_PERIOD_NS = 100;
	localparam int HOLD_TIME_NS = 722000;
	localparam int LINK_TIME_NS = 395000;
	localparam int HOLD_CYCLES = (HOLD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int LINK_CYCLES = (LINK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ********************************
	// Widths and counts
	// ********************************
	localparam int CG_BITS = 5;
	localparam int IDLE_LOCK_GROUPS = 12;
	localparam int IDLE_LOCK_BITS = IDLE_LOCK_GROUPS * CG_BITS;
	localparam int IDLE_HOLD_BITS = 58;
	localparam int IDLE_END_GROUPS = 2;
	localparam int ARM_BITS = IDLE_END_GROUPS * CG_BITS;
	localparam int PEND_BITS = 7;
	localparam int TMR_W = 13;
	localparam int LINK_W = 12;
	localparam int RUN_W = 7;
	localparam int ARM_W = 4;
	localparam int PEND_W = 3;
	localparam int BIT_W = 3;
	localparam int IDLE_W = 2;
	localparam int FC_W = 16;
	localparam int LFSR_W = 11;
	localparam int LFSR_TAP_A = 10;
	localparam int LFSR_TAP_B = 8;
	localparam int FIFO_DEPTH = 4;

	// ********************************
	// Code-groups and nibbles
	// ********************************
	localparam logic [4:0] CG_IDLE = 5'h1F;
	localparam logic [4:0] CG_J = 5'h18;
	localparam logic [4:0] CG_K = 5'h11;
	localparam logic [4:0] CG_T = 5'h0D;
	localparam logic [4:0] CG_R = 5'h07;
	localparam logic [4:0] CG_H = 5'h04;
	localparam logic [3:0] NIB_PRE = 4'h5;
	localparam logic [3:0] NIB_BAD = 4'hE;
	localparam logic [3:0] NIB_ZERO = 4'h0;

	// ********************************
	// Types
	// ********************************
	typedef enum logic [1:0] {FRX_LVL_ZERO, FRX_LVL_POS, FRX_LVL_NEG}
		frx_lvl_t;
	typedef enum logic [1:0] {ST_HUNT, ST_DATA, ST_ENDR, ST_BAD} frx_dec_t;

	typedef struct packed {
		logic [3:0] rxd;
		logic dv;
		logic er;
		logic crs;
	} frx_mii_t;

	localparam int FIFO_WIDTH = $bits(frx_mii_t);

	// ********************************
	// 5B to 4B lookup: {valid, nibble}
	// ********************************
	function automatic logic [4:0] frx_decode5b(input logic [4:0] cg);
		case (cg)
			5'h1E: frx_decode5b = 5'h10;
			5'h09: frx_decode5b = 5'h11;
			5'h14: frx_decode5b = 5'h12;
			5'h15: frx_decode5b = 5'h13;
			5'h0A: frx_decode5b = 5'h14;
			5'h0B: frx_decode5b = 5'h15;
			5'h0E: frx_decode5b = 5'h16;
			5'h0F: frx_decode5b = 5'h17;
			5'h12: frx_decode5b = 5'h18;
			5'h13: frx_decode5b = 5'h19;
			5'h16: frx_decode5b = 5'h1A;
			5'h17: frx_decode5b = 5'h1B;
			5'h1A: frx_decode5b = 5'h1C;
			5'h1B: frx_decode5b = 5'h1D;
			5'h1C: frx_decode5b = 5'h1E;
			5'h1D: frx_decode5b = 5'h1F;
			default: frx_decode5b = 5'h00;
		endcase
	endfunction

endpackage

`default_nettype wire

/* core/frx_fifo.sv */
// Small synchronous FIFO with valid/ready on both sides
// Assumes one clock and a synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none

module frx_fifo #(
	parameter int WIDTH = 7,
	parameter int DEPTH = 4
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Fill side
	input wire logic inValid,
	input wire logic [WIDTH-1:0] inData,
	output logic inReady,
	// Drain side
	output logic outValid,
	output logic [WIDTH-1:0] outData,
	input wire logic outReady
);
	import frx_pkg::*;

	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
	localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0] wp;
		logic [PW-1:0] rp;
		logic [CW-1:0] cnt;
	} frx_fifo_state_t;

	frx_fifo_state_t r_reg;
	frx_fifo_state_t r_next;
	logic doPush;
	logic doPop;

	assign inReady = (r_reg.cnt != FULL_CNT);
	assign outValid = (r_reg.cnt != '0);
	assign outData = r_reg.mem[r_reg.rp];
	assign doPush = inValid && inReady;
	assign doPop = outValid && outReady;

	// ********************************
	// Next state
	// ********************************
	always_comb begin
		r_next = r_reg;
		if (doPush) begin
			r_next.mem[r_reg.wp] = inData;
			r_next.wp = (r_reg.wp == LAST_PTR) ? '0 : r_reg.wp + 1'b1;
		end
		if (doPop) begin
			r_next.rp = (r_reg.rp == LAST_PTR) ? '0 : r_reg.rp + 1'b1;
		end
		if (doPush && !doPop) begin
			r_next.cnt = r_reg.cnt + 1'b1;
		end else if (doPop && !doPush) begin
			r_next.cnt = r_reg.cnt - 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

endmodule

`default_nettype wire

/* core/frx_rx_pcs.sv */
// 100 Mb/s receive PCS: symbol decode, descrambler, aligner, 5B decoder
// Assumes one equalized MLT-3 symbol per clock and a MAC drain handshake
//
// Contract
// - Signal detect stays low when only link pulses arrive.
// - Three-level symbols become a binary NRZI bit stream first.
// - NRZI bits are turned into NRZ before descrambling.
// - Received bits are grouped into 5-bit symbols.
// - Plain bit is scrambled bit XOR a transmitter-identical key sequence.
// - Lock after twelve consecutive idle groups; then emit unaligned groups.
// - On lock a 722 us hold timer runs; 58 idle bits restart it.
// - Hold timer expiry drops lock, resets descrambler, reacquires from idles.
// - Aligner takes descrambler bits, or NRZ bits when bypassed.
// - Boundary is fixed on the J then K pair and held.
// - Each code-group becomes a nibble by table lookup.
// - J/K after idles is replaced by two preamble nibbles 0101.
// - Decoding lasts the packet; stops on T/R or two idles.
// - Link up and PCS enable only after 395 us steady signal detect.
// - Idles to non-idle without J/K first is a bad start.
// - Bad start drives receive error and data 1110 per group.
// - Each bad start adds exactly one to the false-carrier counter.
// - After bad start, error and carrier drop after two idles.
// - Control groups: idle, J/K, T/R and halt use fixed codes.
// - Control or undefined groups inside data decode invalid with error.
// - Key generator is a closed-loop 11-bit LFSR matching transmit.
`timescale 1ns/1ps
`default_nettype none

module frx_rx_pcs #(
	parameter logic [frx_pkg::TMR_W-1:0] HOLD_CYC =
		frx_pkg::TMR_W'(frx_pkg::HOLD_CYCLES)
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Line side
	input wire frx_pkg::frx_lvl_t symLevel,
	input wire logic sigEnergy,
	input wire logic pulseOnly,
	input wire logic descBypass,
	// MAC side
	input wire logic macReady,
	output logic [3:0] rxd,
	output logic rxDv,
	output logic rxEr,
	output logic crs,
	// Status
	output logic sigDetect,
	output logic linkUp,
	output logic descLocked,
	output logic bufReady,
	output logic [frx_pkg::FC_W-1:0] falseCarrierEventCounter
);
	import frx_pkg::*;

	localparam logic [LINK_W-1:0] LINK_LAST = LINK_W'(LINK_CYCLES - 1);
	localparam logic [RUN_W-1:0] LOCK_LAST = RUN_W'(IDLE_LOCK_BITS - 1);
	localparam logic [RUN_W-1:0] HOLD_LAST = RUN_W'(IDLE_HOLD_BITS - 1);
	localparam logic [ARM_W-1:0] ARM_FULL = ARM_W'(ARM_BITS);
	localparam logic [PEND_W-1:0] PEND_LOAD = PEND_W'(PEND_BITS);
	localparam logic [PEND_W-1:0] PEND_LAST = PEND_W'(1);
	localparam logic [BIT_W-1:0] BIT_LAST = BIT_W'(CG_BITS - 1);
	localparam logic [IDLE_W-1:0] IDLE_LAST = IDLE_W'(IDLE_END_GROUPS - 1);

	localparam frx_mii_t ENT_END = '{rxd: NIB_ZERO, dv: 1'b0, er: 1'b0,
		crs: 1'b0};
	localparam frx_mii_t ENT_PRE = '{rxd: NIB_PRE, dv: 1'b1, er: 1'b0,
		crs: 1'b1};
	localparam frx_mii_t ENT_ERR = '{rxd: NIB_ZERO, dv: 1'b1, er: 1'b1,
		crs: 1'b1};
	localparam frx_mii_t ENT_BAD = '{rxd: NIB_BAD, dv: 1'b0, er: 1'b1,
		crs: 1'b1};

	// ********************************
	// State
	// ********************************
	typedef struct packed {
		logic sigDet;
		logic [LINK_W-1:0] linkTmr;
		logic linkUp;
		logic nrziPrev;
		logic [LFSR_W-1:0] lfsr;
		logic locked;
		logic [RUN_W-1:0] lockRun;
		logic [RUN_W-1:0] idleRun;
		logic [TMR_W-1:0] holdTmr;
		logic [9:0] window;
		logic aligned;
		logic [BIT_W-1:0] bitCnt;
		logic [ARM_W-1:0] armRun;
		logic [PEND_W-1:0] pend;
		frx_dec_t dec;
		logic [IDLE_W-1:0] idleCnt;
		logic pre2;
		logic pushV;
		frx_mii_t pushD;
		logic bufRdy;
		frx_mii_t mii;
		logic [FC_W-1:0] fcCnt;
	} frx_state_t;

	frx_state_t r_reg;
	frx_state_t r_next;
	logic fifoInReady;
	logic fifoOutValid;
	logic [FIFO_WIDTH-1:0] fifoOutData;
	logic fifoPop;

	assign fifoPop = fifoOutValid && macReady;

	frx_fifo #(
		.WIDTH(FIFO_WIDTH),
		.DEPTH(FIFO_DEPTH)
	) frx_fifo_inst (
		.clk(clk),
		.rstn(rstn),
		.inValid(r_reg.pushV),
		.inData(r_reg.pushD),
		.inReady(fifoInReady),
		.outValid(fifoOutValid),
		.outData(fifoOutData),
		.outReady(fifoPop)
	);

	// ********************************
	// Next state
	// ********************************
	always_comb begin
		logic nrzi;
		logic nrz;
		logic key;
		logic ud;
		logic bitIn;
		logic streamOk;
		logic [9:0] nw;
		logic [4:0] cg;
		logic [4:0] dec5;
		logic isIdle;
		nrzi = 1'b0;
		nrz = 1'b0;
		key = 1'b0;
		ud = 1'b0;
		bitIn = 1'b0;
		streamOk = 1'b0;
		nw = '0;
		cg = '0;
		dec5 = '0;
		isIdle = 1'b0;
		r_next = r_reg;
		r_next.pushV = 1'b0;
		r_next.bufRdy = fifoInReady;

		// Signal detect and link monitor
		r_next.sigDet = sigEnergy && !pulseOnly;
		if (!r_reg.sigDet) begin
			r_next.linkTmr = '0;
			r_next.linkUp = 1'b0;
		end else if (r_reg.linkTmr == LINK_LAST) begin
			r_next.linkUp = 1'b1;
		end else begin
			r_next.linkTmr = r_reg.linkTmr + 1'b1;
		end

		// Line decode
		nrzi = (symLevel != FRX_LVL_ZERO);
		nrz = nrzi ^ r_reg.nrziPrev;
		r_next.nrziPrev = nrzi;

		// Descrambler
		key = r_reg.lfsr[LFSR_TAP_A] ^ r_reg.lfsr[LFSR_TAP_B];
		ud = nrz ^ key;
		if (!r_reg.linkUp) begin
			r_next.lfsr = '0;
			r_next.locked = 1'b0;
			r_next.lockRun = '0;
			r_next.idleRun = '0;
			r_next.holdTmr = '0;
		end else if (!r_reg.locked) begin
			// Idle assumed while hunting, so key is the inverted line bit
			r_next.lfsr = {r_reg.lfsr[LFSR_W-2:0], ~nrz};
			r_next.lockRun = ud ? r_reg.lockRun + 1'b1 : '0;
			if (ud && r_reg.lockRun == LOCK_LAST) begin
				r_next.locked = 1'b1;
				r_next.holdTmr = HOLD_CYC;
				r_next.idleRun = '0;
			end
		end else begin
			r_next.lfsr = {r_reg.lfsr[LFSR_W-2:0], key};
			if (!ud) begin
				r_next.idleRun = '0;
			end else if (r_reg.idleRun != HOLD_LAST) begin
				r_next.idleRun = r_reg.idleRun + 1'b1;
			end
			if (ud && r_reg.idleRun == HOLD_LAST) begin
				r_next.holdTmr = HOLD_CYC;
			end else if (r_reg.holdTmr == '0) begin
				r_next.locked = 1'b0;
				r_next.lfsr = '0;
				r_next.lockRun = '0;
				r_next.idleRun = '0;
			end else begin
				r_next.holdTmr = r_reg.holdTmr - 1'b1;
			end
		end

		// Aligner input
		bitIn = descBypass ? nrz : ud;
		streamOk = r_reg.linkUp && (descBypass || r_reg.locked);
		nw = {r_reg.window[8:0], bitIn};
		r_next.window = nw;
		r_next.pre2 = 1'b0;

		if (!streamOk) begin
			if (r_reg.dec != ST_HUNT) begin
				r_next.pushV = 1'b1;
				r_next.pushD = ENT_END;
			end
			r_next.aligned = 1'b0;
			r_next.dec = ST_HUNT;
			r_next.armRun = '0;
			r_next.pend = '0;
		end else if (!r_reg.aligned) begin
			if (bitIn && r_reg.armRun != ARM_FULL && r_reg.pend == '0) begin
				r_next.armRun = r_reg.armRun + 1'b1;
			end else if (!bitIn && r_reg.armRun != ARM_FULL) begin
				r_next.armRun = '0;
			end
			if (r_reg.armRun == ARM_FULL && nw == {CG_J, CG_K}) begin
				r_next.aligned = 1'b1;
				r_next.bitCnt = '0;
				r_next.dec = ST_DATA;
				r_next.idleCnt = '0;
				r_next.pend = '0;
				r_next.armRun = '0;
				r_next.pushV = 1'b1;
				r_next.pushD = ENT_PRE;
				r_next.pre2 = 1'b1;
			end else if (r_reg.pend != '0) begin
				r_next.pend = r_reg.pend - 1'b1;
				if (r_reg.pend == PEND_LAST) begin
					r_next.aligned = 1'b1;
					r_next.bitCnt = '0;
					r_next.dec = ST_BAD;
					r_next.idleCnt = '0;
					r_next.armRun = '0;
					r_next.fcCnt = r_reg.fcCnt + 1'b1;
					r_next.pushV = 1'b1;
					r_next.pushD = ENT_BAD;
				end
			end else if (!bitIn && r_reg.armRun == ARM_FULL) begin
				r_next.pend = PEND_LOAD;
			end
		end else begin
			r_next.bitCnt = (r_reg.bitCnt == BIT_LAST) ? '0 :
				r_reg.bitCnt + 1'b1;
			if (r_reg.pre2) begin
				r_next.pushV = 1'b1;
				r_next.pushD = ENT_PRE;
			end
			if (r_reg.bitCnt == BIT_LAST) begin
				cg = nw[4:0];
				isIdle = (cg == CG_IDLE);
				r_next.idleCnt = isIdle ?
					((r_reg.idleCnt == IDLE_LAST) ? r_reg.idleCnt :
					r_reg.idleCnt + 1'b1) : '0;
				dec5 = frx_decode5b(cg);
				r_next.pushV = 1'b1;
				case (r_reg.dec)
					ST_DATA: begin
						if (isIdle && r_reg.idleCnt == IDLE_LAST) begin
							r_next.pushD = ENT_END;
							r_next.dec = ST_HUNT;
						end else if (cg == CG_T) begin
							r_next.pushV = 1'b0;
							r_next.dec = ST_ENDR;
						end else if (dec5[4]) begin
							r_next.pushD = '{rxd: dec5[3:0], dv: 1'b1,
								er: 1'b0, crs: 1'b1};
						end else begin
							r_next.pushD = ENT_ERR;
						end
					end
					ST_ENDR: begin
						if (cg == CG_R) begin
							r_next.pushD = ENT_END;
							r_next.dec = ST_HUNT;
						end else begin
							r_next.pushD = ENT_ERR;
							r_next.dec = ST_DATA;
						end
					end
					ST_BAD: begin
						if (isIdle && r_reg.idleCnt == IDLE_LAST) begin
							r_next.pushD = ENT_END;
							r_next.dec = ST_HUNT;
						end else begin
							r_next.pushD = ENT_BAD;
						end
					end
					default: begin
						r_next.pushV = 1'b0;
						r_next.dec = ST_HUNT;
					end
				endcase
				if (r_next.dec == ST_HUNT) begin
					r_next.aligned = 1'b0;
					r_next.armRun = ARM_FULL;
				end
			end
		end

		// MAC output stage
		if (fifoPop) begin
			r_next.mii = frx_mii_t'(fifoOutData);
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	// ********************************
	// Outputs
	// ********************************
	assign rxd = r_reg.mii.rxd;
	assign rxDv = r_reg.mii.dv;
	assign rxEr = r_reg.mii.er;
	assign crs = r_reg.mii.crs;
	assign sigDetect = r_reg.sigDet;
	assign linkUp = r_reg.linkUp;
	assign descLocked = r_reg.locked;
	assign bufReady = r_reg.bufRdy;
	assign falseCarrierEventCounter = r_reg.fcCnt;

endmodule

`default_nettype wire

/* tb/frx_rx_pcs_asserts.sv */
// Port assertions for the receive PCS
// Assumes binding onto frx_rx_pcs with its hold parameter
`timescale 1ns/1ps
`default_nettype none

module frx_rx_pcs_asserts #(
	parameter logic [frx_pkg::TMR_W-1:0] HOLD_CYC =
		frx_pkg::TMR_W'(frx_pkg::HOLD_CYCLES)
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Inputs
	input wire frx_pkg::frx_lvl_t symLevel,
	input wire logic sigEnergy,
	input wire logic pulseOnly,
	input wire logic descBypass,
	input wire logic macReady,
	// Outputs
	input wire logic [3:0] rxd,
	input wire logic rxDv,
	input wire logic rxEr,
	input wire logic crs,
	input wire logic sigDetect,
	input wire logic linkUp,
	input wire logic descLocked,
	input wire logic bufReady,
	input wire logic [frx_pkg::FC_W-1:0] falseCarrierEventCounter
);
	import frx_pkg::*;
	logic [12:0] detCnt;
	logic [12:0] lockCnt;

	// Steady detect and lock run lengths
	always_ff @(posedge clk) begin
		if (!rstn || !sigDetect) detCnt <= '0;
		else if (detCnt != '1) detCnt <= detCnt + 1'b1;
		if (!rstn || !descLocked) lockCnt <= '0;
		else if (lockCnt != '1) lockCnt <= lockCnt + 1'b1;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	a_detect_gate: assert property (
		$past(rstn) |-> sigDetect == $past(sigEnergy && !pulseOnly))
		else $error("signal detect mismatch");
	a_link_wait: assert property (
		$rose(linkUp) |-> detCnt >= 13'(LINK_CYCLES - 2))
		else $error("link up too early");
	a_lock_link: assert property (
		$rose(descLocked) |-> linkUp)
		else $error("lock without link");
	a_hold_expiry: assert property (
		$fell(descLocked) && linkUp |-> lockCnt >= HOLD_CYC - 13'h0002)
		else $error("lock dropped early");
	a_fc_step: assert property (
		$changed(falseCarrierEventCounter) |->
		falseCarrierEventCounter == $past(falseCarrierEventCounter) + 1'b1)
		else $error("counter step wrong");
	a_bad_nibble: assert property (
		rxEr && !rxDv |-> rxd == NIB_BAD && crs)
		else $error("bad start nibble wrong");
	a_err_nibble: assert property (
		rxEr && rxDv |-> rxd == NIB_ZERO)
		else $error("error nibble wrong");
	a_end_quiet: assert property (
		!rxEr && !rxDv |-> !crs)
		else $error("carrier left up");
	a_out_hold: assert property (
		$past(rstn) && !$past(macReady) |-> $stable({rxd, rxDv, rxEr, crs}))
		else $error("output moved without pop");

	c_locked: cover property ($rose(descLocked));
	c_frame: cover property ($rose(rxDv));
	c_bad: cover property ($changed(falseCarrierEventCounter));
endmodule

bind frx_rx_pcs frx_rx_pcs_asserts #(.HOLD_CYC(HOLD_CYC))
	frx_rx_pcs_asserts_inst (
	.clk(clk), .rstn(rstn), .symLevel(symLevel), .sigEnergy(sigEnergy),
	.pulseOnly(pulseOnly), .descBypass(descBypass), .macReady(macReady),
	.rxd(rxd), .rxDv(rxDv), .rxEr(rxEr), .crs(crs), .sigDetect(sigDetect),
	.linkUp(linkUp), .descLocked(descLocked), .bufReady(bufReady),
	.falseCarrierEventCounter(falseCarrierEventCounter)
);

`default_nettype wire

/* tb/frx_mac_model.sv */
// MAC model on the receive nibble side
// Assumes outputs change only when an entry is taken
`timescale 1ns/1ps
`default_nettype none

module frx_mac_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Bench control
	input wire logic stall,
	// Receive side
	input wire logic [3:0] rxd,
	input wire logic rxDv,
	input wire logic rxEr,
	input wire logic crs,
	output logic macReady
);
	import frx_pkg::*;
	frx_mii_t seen[$];
	frx_mii_t last;
	frx_mii_t cur;

	assign cur = frx_mii_t'({rxd, rxDv, rxEr, crs});

	// Take entries unless stalled; log each new output state
	always @(posedge clk) begin
		macReady <= rstn && !stall;
		if (!rstn) begin
			last <= '0;
		end else if (cur !== last) begin
			last <= cur;
			seen.push_back(cur);
		end
	end
endmodule

`default_nettype wire

/* tb/test_frx_rx_pcs.sv */
// Testbench for the receive PCS
// Assumes the MAC model and the bound checker
`timescale 1ns/1ps
`default_nettype none

module test_frx_rx_pcs;
	import frx_pkg::*;
	localparam logic [TMR_W-1:0] HOLD_SMALL = 13'h00C8;
	logic clk, rstn, sigEnergy, pulseOnly, descBypass, macReady, stall;
	frx_lvl_t symLevel;
	logic [3:0] rxd;
	logic rxDv, rxEr, crs, sigDetect, linkUp, descLocked, bufReady;
	logic [FC_W-1:0] fcCount;
	logic [10:0] scr;
	logic [1:0] mlt;
	logic scrOn;
	int n_errors, comparisons;
	logic [4:0] dataCg [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B,
		5'h0E, 5'h0F, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};

	frx_rx_pcs #(.HOLD_CYC(HOLD_SMALL)) frx_rx_pcs_inst (
		.clk(clk), .rstn(rstn), .symLevel(symLevel), .sigEnergy(sigEnergy),
		.pulseOnly(pulseOnly), .descBypass(descBypass), .macReady(macReady),
		.rxd(rxd), .rxDv(rxDv), .rxEr(rxEr), .crs(crs), .sigDetect(sigDetect),
		.linkUp(linkUp), .descLocked(descLocked), .bufReady(bufReady),
		.falseCarrierEventCounter(fcCount)
	);
	frx_mac_model frx_mac_model_inst (
		.clk(clk), .rstn(rstn), .stall(stall), .rxd(rxd), .rxDv(rxDv),
		.rxEr(rxEr), .crs(crs), .macReady(macReady)
	);

	// ****************
	// Helpers
	// ****************
	task automatic complete_run;
		$display("n_errors=%0d comparisons=%0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic must(input logic v);
		check(v, 1'b1);
		if (v !== 1'b1) complete_run();
	endtask
	function automatic frx_mii_t ent(input logic [3:0] n, input logic [2:0] f);
		return frx_mii_t'({n, f});
	endfunction
	task automatic send_bit(input logic ub);
		logic k;
		logic sb;
		k = scr[10] ^ scr[8];
		sb = scrOn ? ub ^ k : ub;
		if (scrOn) scr = {scr[9:0], k};
		mlt = mlt + {1'b0, sb};
		@(negedge clk);
		symLevel = !mlt[0] ? FRX_LVL_ZERO : (mlt[1] ? FRX_LVL_NEG : FRX_LVL_POS);
	endtask
	task automatic send_cg(input logic [4:0] cg);
		for (int i = 4; i >= 0; i--) send_bit(cg[i]);
	endtask
	task automatic idles(input int n);
		repeat (n) send_cg(CG_IDLE);
	endtask
	task automatic check_rx(input frx_mii_t exp[$]);
		idles(6);
		check(16'(frx_mac_model_inst.seen.size()), 16'(exp.size()));
		foreach (exp[i]) check(frx_mac_model_inst.seen[i], exp[i]);
		frx_mac_model_inst.seen.delete();
	endtask

	// ****************
	// Scenarios
	// ****************
	task automatic s_link_up;
		sigEnergy = 1'b1;
		idles(2);
		check(sigDetect, 1'b0);
		pulseOnly = 1'b0;
		repeat (LINK_CYCLES - 10) send_bit(1'b1);
		check(linkUp, 1'b0);
		for (int i = 0; i < 20 && linkUp !== 1'b1; i++) send_bit(1'b1);
		must(linkUp);
	endtask
	task automatic s_bypass_frame;
		frx_mii_t exp[$];
		logic [4:0] tail[4] = '{CG_H, dataCg[7], CG_T, CG_R};
		idles(12);
		repeat (3) send_bit(1'b1);
		send_cg(CG_J);
		send_cg(CG_K);
		exp.push_back(ent(NIB_PRE, 3'b101));
		for (int n = 0; n < 16; n++) begin
			send_cg(dataCg[n]);
			exp.push_back(ent(4'(n), 3'b101));
		end
		foreach (tail[i]) send_cg(tail[i]);
		exp.push_back(ent(NIB_ZERO, 3'b111));
		exp.push_back(ent(4'h7, 3'b101));
		exp.push_back(ent(NIB_ZERO, 3'b000));
		check_rx(exp);
	endtask
	task automatic s_bad_start;
		logic [FC_W-1:0] fc0;
		frx_mii_t exp[$];
		fc0 = fcCount;
		idles(4);
		send_cg(CG_H);
		send_cg(dataCg[5]);
		exp.push_back(ent(NIB_BAD, 3'b011));
		exp.push_back(ent(NIB_ZERO, 3'b000));
		check_rx(exp);
		check(fcCount, fc0 + 1'b1);
	endtask
	task automatic s_buffer_full;
		frx_mii_t exp[$];
		stall = 1'b1;
		idles(4);
		send_cg(CG_J);
		send_cg(CG_K);
		for (int n = 1; n < 7; n++) send_cg(dataCg[n]);
		check(bufReady, 1'b0);
		stall = 1'b0;
		send_cg(CG_T);
		send_cg(CG_R);
		exp = '{ent(NIB_PRE, 3'b101), ent(4'h1, 3'b101), ent(4'h2, 3'b101),
			ent(NIB_ZERO, 3'b000)};
		check_rx(exp);
	endtask
	task automatic s_scrambled;
		frx_mii_t exp[$];
		descBypass = 1'b0;
		scrOn = 1'b1;
		idles(12);
		for (int i = 0; i < 40 && descLocked !== 1'b1; i++) send_bit(1'b1);
		must(descLocked);
		idles(2);
		send_cg(CG_J);
		send_cg(CG_K);
		send_cg(dataCg[10]);
		send_cg(dataCg[12]);
		send_cg(CG_T);
		send_cg(CG_R);
		exp = '{ent(NIB_PRE, 3'b101), ent(4'hA, 3'b101), ent(4'hC, 3'b101),
			ent(NIB_ZERO, 3'b000)};
		check_rx(exp);
		send_cg(CG_J);
		send_cg(CG_K);
		send_cg(dataCg[3]);
		exp = '{ent(NIB_PRE, 3'b101), ent(4'h3, 3'b101), ent(NIB_ZERO, 3'b111),
			ent(NIB_ZERO, 3'b000)};
		check_rx(exp);
	endtask
	task automatic s_hold_expiry;
		logic [FC_W-1:0] fc0;
		frx_mii_t exp[$];
		fc0 = fcCount;
		for (int i = 0; i < 60; i++) begin
			send_cg(CG_IDLE);
			check(descLocked, 1'b1);
		end
		for (int i = 0; i < 60 && descLocked !== 1'b0; i++) send_cg(dataCg[4]);
		must(descLocked === 1'b0);
		for (int i = 0; i < 100 && descLocked !== 1'b1; i++) send_bit(1'b1);
		must(descLocked);
		exp = '{ent(NIB_BAD, 3'b011), ent(NIB_ZERO, 3'b000)};
		check_rx(exp);
		check(fcCount, fc0 + 1'b1);
	endtask

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	initial begin
		n_errors = 0;
		comparisons = 0;
		rstn = 1'b0;
		sigEnergy = 1'b0;
		pulseOnly = 1'b1;
		descBypass = 1'b1;
		stall = 1'b0;
		symLevel = FRX_LVL_ZERO;
		scr = 11'h5A3;
		mlt = 2'h0;
		scrOn = 1'b0;
		repeat (5) @(negedge clk);
		rstn = 1'b1;
		s_link_up();
		s_bypass_frame();
		s_bad_start();
		s_buffer_full();
		s_scrambled();
		s_hold_expiry();
		complete_run();
	end
endmodule

`default_nettype wire
